/* design/dpcs_defs.svh */
// Constants for the dual phase counter status block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DPCS_DEFS_SVH
`define DPCS_DEFS_SVH
`define DPCS_CNT_W 32
`define DPCS_STAT_W 8
`define DPCS_BIT_RUN 0
`define DPCS_BIT_VALID 1
`define DPCS_BIT_WRAP 2
`define DPCS_BIT_LOAD 3
`define DPCS_BIT_LATCH 4
`define DPCS_WIDE_MIN 32'sh80000000
`define DPCS_WIDE_MAX 32'sh7ffffffe
`define DPCS_MOD_MAX 32'sh7fffffff
`define DPCS_CNT_RST 32'h00000000
`define DPCS_STAT_RST 8'h00
`endif

/* design/dpcs_pkg.sv */
// Types for the dual phase counter status block.
// Assumes the constants header is on the include path.
`include "dpcs_defs.svh"
package dpcs_pkg;
  typedef enum logic [1:0] {
    DPCS_MODE_WRAP = 2'b01,
    DPCS_MODE_WIDE = 2'b10
  } dpcs_mode_type;
  typedef struct packed {
    logic enable;
    logic preset;
    logic capture;
    logic ack_wrap;
    logic ack_load;
    logic ack_latch;
  } dpcs_cond_type;
  typedef struct packed {
    logic [`DPCS_CNT_W-1:0] count;
    logic [`DPCS_CNT_W-1:0] latched;
    logic [`DPCS_STAT_W-1:0] status;
  } dpcs_report_type;
endpackage : dpcs_pkg

/* design/dpcs_counter.sv */
// Dual phase counter channel with its count, latched count and status byte.
// Assumes conditions arrive from pins or the host bus image and need syncing.
`timescale 1ns/1ns
`default_nettype none
`include "dpcs_defs.svh"

// What this block does
// R01: Count and latched count are signed 32-bit, refreshed every bus cycle.
// R02: Wrap mode count stays 0..2147483647; wide mode stays min..2147483646.
// R03: Latched count is flagged valid only while the latch flag is set.
// R04: Status is one byte; bits 0-4 are active, valid, wrap, load, latch.
// R05: Active bit follows the enable condition.
// R06: In wide mode without rollover a limit clears active until a preset rising edge.
// R07: Valid bit set while count in range, cleared when inactive or outside.
// R08: Wrap flag sets when counter returns to 0 after the modulo value.
// R09: Wrap flag clears on a rising edge of the wrap acknowledge bit.
// R10: Load flag sets when the preset condition is asserted.
// R11: Latch flag sets on a rising edge of the capture condition.
// R12: Wrap mode loops at a configurable modulo value 0..2147483647.
// R13: Wide mode with rollover jumps to the opposite limit at a limit.
// R14: Wide mode loads the preset value on each preset rising edge.
// R15: Latch flag clears on a rising edge of acknowledge command bit 12.
// R16: Load flag clears on a rising edge of the load acknowledge bit.
module dpcs_counter (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // Count pulses and configuration.
  input wire logic up_in,
  input wire logic down_in,
  input wire dpcs_pkg::dpcs_mode_type mode_in,
  input wire logic rollover_in,
  input wire logic [31:0] modulo_in,
  input wire logic [31:0] preset_val_in,
  // Conditions and host acknowledges.
  input wire dpcs_pkg::dpcs_cond_type cond_in,
  // Host bus cycle strobe.
  input wire logic bus_cycle_in,
  // Reported values.
  output var dpcs_pkg::dpcs_report_type report_out,
  output logic latched_valid_out
);

  localparam int CW = $bits(dpcs_pkg::dpcs_cond_type);

  logic [CW-1:0] sync1_q;
  logic [CW-1:0] sync2_q;
  logic [CW-1:0] prev_q;
  logic up1_q, up2_q, dn1_q, dn2_q;
  dpcs_pkg::dpcs_cond_type c;
  dpcs_pkg::dpcs_cond_type rise;
  logic signed [31:0] count_q;
  logic signed [31:0] count_d;
  logic signed [31:0] latched_q;
  logic halted_q;
  logic wrap_q, load_q, latch_q;
  logic wrapped;
  logic at_limit;
  logic run;
  logic valid;
  logic step_up, step_dn;

  function automatic logic in_range(input dpcs_pkg::dpcs_mode_type m, input logic signed [31:0] v,
                                    input logic signed [31:0] modv);
    if (m == dpcs_pkg::DPCS_MODE_WRAP)
      in_range = (v >= 0) && (v <= modv);
    else
      in_range = (v <= `DPCS_WIDE_MAX);
  endfunction : in_range

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
      up1_q <= 1'b0;
      up2_q <= 1'b0;
      dn1_q <= 1'b0;
      dn2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= cond_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      up1_q <= up_in;
      up2_q <= up1_q;
      dn1_q <= down_in;
      dn2_q <= dn1_q;
    end
  end

  assign c = sync2_q;
  assign rise = sync2_q & ~prev_q;
  assign step_up = up2_q & ~dn2_q;
  assign step_dn = dn2_q & ~up2_q;

  // Active follows enable; a wide-mode limit without rollover halts until a preset edge.
  assign run = c.enable & ~halted_q; // [R05] [R06]
  assign valid = run & in_range(mode_in, count_q, $signed(modulo_in)); // [R07]

  always_comb
  begin
    count_d = count_q;
    wrapped = 1'b0;
    at_limit = 1'b0;
    if (mode_in == dpcs_pkg::DPCS_MODE_WIDE && rise.preset)
      count_d = $signed(preset_val_in); // [R14]
    else if (run)
    begin
      if (mode_in == dpcs_pkg::DPCS_MODE_WRAP)
      begin
        if (step_up)
        begin
          if (count_q >= $signed(modulo_in))
          begin
            count_d = '0; // [R12] [R08]
            wrapped = 1'b1;
          end
          else
            count_d = count_q + 32'sd1;
        end
        else if (step_dn)
          count_d = (count_q <= 0) ? $signed(modulo_in) : count_q - 32'sd1; // [R02]
      end
      else
      begin
        if (step_up)
        begin
          if (count_q >= `DPCS_WIDE_MAX)
          begin
            at_limit = 1'b1;
            count_d = rollover_in ? `DPCS_WIDE_MIN : count_q; // [R13] [R02]
          end
          else
            count_d = count_q + 32'sd1;
        end
        else if (step_dn)
        begin
          if (count_q == `DPCS_WIDE_MIN)
          begin
            at_limit = 1'b1;
            count_d = rollover_in ? `DPCS_WIDE_MAX : count_q; // [R13]
          end
          else
            count_d = count_q - 32'sd1;
        end
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      count_q <= `DPCS_CNT_RST;
    else
      count_q <= count_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      halted_q <= 1'b0;
    else if (rise.preset)
      halted_q <= 1'b0; // [R06]
    else if (at_limit && !rollover_in)
      halted_q <= 1'b1; // [R06]
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      latched_q <= `DPCS_CNT_RST;
    else if (rise.capture)
      latched_q <= count_q;
  end

  // Flags: a set in the same cycle as a clear wins.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      wrap_q <= 1'b0;
    else if (wrapped)
      wrap_q <= 1'b1; // [R08]
    else if (rise.ack_wrap)
      wrap_q <= 1'b0; // [R09]
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      load_q <= 1'b0;
    else if (c.preset)
      load_q <= 1'b1; // [R10]
    else if (rise.ack_load)
      load_q <= 1'b0; // [R16]
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      latch_q <= 1'b0;
    else if (rise.capture)
      latch_q <= 1'b1; // [R11]
    else if (rise.ack_latch)
      latch_q <= 1'b0; // [R15]
  end

  // Reported image refreshes once per host bus cycle.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      report_out <= '0;
      latched_valid_out <= 1'b0;
    end
    else if (bus_cycle_in)
    begin
      report_out.count <= count_q; // [R01]
      report_out.latched <= latched_q; // [R01]
      report_out.status <= {3'h0, latch_q, load_q, wrap_q, valid, run}; // [R04]
      latched_valid_out <= latch_q; // [R03]
    end
  end

  sequence ack_latch_rise_s;
    rise.ack_latch && !rise.capture;
  endsequence

  wrap_range_a: assert property (@(posedge clk_in) disable iff (srst_in)
    mode_in == dpcs_pkg::DPCS_MODE_WRAP && $signed(modulo_in) >= 0 && in_range(mode_in, count_q, $signed(modulo_in))
    && $stable(mode_in) && $stable(modulo_in) && !rise.preset |=> count_q >= 0 && count_q <= $signed(modulo_in)) // [R02]
    else $error("Wrap count out of range.");
  report_refresh_a: assert property (@(posedge clk_in) disable iff (srst_in)
    bus_cycle_in |=> report_out.count == $past(count_q) && report_out.latched == $past(latched_q)) // [R01]
    else $error("Report not refreshed.");
  latch_valid_a: assert property (@(posedge clk_in) disable iff (srst_in)
    bus_cycle_in |=> latched_valid_out == $past(latch_q) && report_out.status[`DPCS_BIT_LATCH] == $past(latch_q)) // [R03]
    else $error("Latched valid mismatch.");
  status_upper_a: assert property (@(posedge clk_in) disable iff (srst_in)
    report_out.status[7:5] == 3'h0) // [R04]
    else $error("Reserved status bits set.");
  run_enable_a: assert property (@(posedge clk_in) disable iff (srst_in)
    bus_cycle_in && !c.enable |=> !report_out.status[`DPCS_BIT_RUN]) // [R05]
    else $error("Active without enable.");
  limit_halt_a: assert property (@(posedge clk_in) disable iff (srst_in)
    at_limit && !rollover_in && !rise.preset |=> !run) // [R06]
    else $error("Limit did not halt.");
  valid_off_a: assert property (@(posedge clk_in) disable iff (srst_in)
    bus_cycle_in && !run |=> !report_out.status[`DPCS_BIT_VALID]) // [R07]
    else $error("Valid while inactive.");
  wrap_flag_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wrapped |=> wrap_q && count_q == 0) // [R08]
    else $error("Wrap flag not set.");
  wrap_ack_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rise.ack_wrap && !wrapped |=> !wrap_q) // [R09]
    else $error("Wrap flag not cleared.");
  load_flag_a: assert property (@(posedge clk_in) disable iff (srst_in)
    c.preset |=> load_q) // [R10]
    else $error("Load flag not set.");
  latch_flag_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rise.capture |=> latch_q && latched_q == $past(count_q)) // [R11]
    else $error("Latch flag or value wrong.");
  rollover_a: assert property (@(posedge clk_in) disable iff (srst_in)
    at_limit && rollover_in && step_up |=> count_q == `DPCS_WIDE_MIN) // [R13]
    else $error("Rollover missed.");
  preset_load_a: assert property (@(posedge clk_in) disable iff (srst_in)
    mode_in == dpcs_pkg::DPCS_MODE_WIDE && rise.preset |=> count_q == $past(preset_val_in)) // [R14]
    else $error("Preset not loaded.");
  latch_ack_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ack_latch_rise_s |=> !latch_q) // [R15]
    else $error("Latch flag not cleared.");
  load_ack_a: assert property (@(posedge clk_in) disable iff (srst_in)
    rise.ack_load && !c.preset |=> !load_q) // [R16]
    else $error("Load flag not cleared.");
  wrap_loop_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wrapped |-> count_q >= $signed(modulo_in)) // [R12]
    else $error("Loop before modulo.");

endmodule : dpcs_counter
`default_nettype wire

/* tb/dpcs_host.sv */
// Host controller model that marks the I/O bus cycles.
// Assumes the bench supplies clock and synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module dpcs_host (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // Bus cycle strobe.
  output logic bus_cycle_out
);
  logic [1:0] div_q;
  always_ff @(posedge clk_in)
  begin
    div_q <= srst_in ? 2'h0 : div_q + 2'h1;
    bus_cycle_out <= !srst_in && div_q == 2'h3;
  end
endmodule : dpcs_host
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the dual phase counter status block.
// Assumes the design package and header are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic up = 1'b0;
  logic down = 1'b0;
  logic roll = 1'b0;
  logic bus;
  logic lv;
  logic [31:0] modv = 32'h00000003;
  logic [31:0] pval = 32'h00000000;
  dpcs_pkg::dpcs_mode_type mode = dpcs_pkg::DPCS_MODE_WRAP;
  dpcs_pkg::dpcs_cond_type cond = '0;
  dpcs_pkg::dpcs_report_type rep;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  dpcs_host host (.clk_in(clk), .srst_in(srst), .bus_cycle_out(bus));
  dpcs_counter dut (.clk_in(clk), .srst_in(srst), .up_in(up), .down_in(down), .mode_in(mode),
    .rollover_in(roll), .modulo_in(modv), .preset_val_in(pval), .cond_in(cond),
    .bus_cycle_in(bus), .report_out(rep), .latched_valid_out(lv));
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  end
  endtask : chk_word
  task automatic chk_stat(input logic [7:0] got, input logic [7:0] exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t status %h expected %h", $time, got, exp);
    end
  end
  endtask : chk_stat
  task automatic settle();
  begin
    repeat (14) @(posedge clk);
    #1;
  end
  endtask : settle
  task automatic step_up(input int n);
  begin
    up = 1'b1;
    repeat (n) @(posedge clk);
    #1 up = 1'b0;
    settle();
  end
  endtask : step_up
  task automatic step_down(input int n);
  begin
    down = 1'b1;
    repeat (n) @(posedge clk);
    #1 down = 1'b0;
    settle();
  end
  endtask : step_down
  task automatic test_run_latch();
  begin
    cond.enable = 1'b1;
    step_up(2);
    chk_word(rep.count, 32'h00000002);
    chk_stat(rep.status, 8'h03);
    cond.capture = 1'b1;
    settle();
    chk_word(rep.latched, 32'h00000002);
    chk_stat(rep.status, 8'h13);
    chk_stat({7'h00, lv}, 8'h01);
    cond.capture = 1'b0;
    cond.ack_latch = 1'b1;
    settle();
    cond.ack_latch = 1'b0;
    chk_stat(rep.status, 8'h03);
    chk_stat({7'h00, lv}, 8'h00);
    $display("test run_latch done");
  end
  endtask : test_run_latch
  task automatic test_wrap();
  begin
    step_up(2);
    chk_word(rep.count, 32'h00000000);
    chk_stat(rep.status, 8'h07);
    cond.ack_wrap = 1'b1;
    settle();
    cond.ack_wrap = 1'b0;
    chk_stat(rep.status, 8'h03);
    $display("test wrap done");
  end
  endtask : test_wrap
  task automatic test_down();
  begin
    step_down(1);
    chk_word(rep.count, 32'h00000003);
    chk_stat(rep.status, 8'h03);
    step_down(2);
    chk_word(rep.count, 32'h00000001);
    cond.preset = 1'b1;
    settle();
    cond.preset = 1'b0;
    chk_word(rep.count, 32'h00000001);
    chk_stat(rep.status, 8'h0b);
    cond.ack_load = 1'b1;
    settle();
    cond.ack_load = 1'b0;
    chk_stat(rep.status, 8'h03);
    cond.enable = 1'b0;
    settle();
    chk_stat(rep.status, 8'h00);
    step_up(1);
    chk_word(rep.count, 32'h00000001);
    cond.enable = 1'b1;
    settle();
    chk_stat(rep.status, 8'h03);
    $display("test down done");
  end
  endtask : test_down
  task automatic test_wide();
  begin
    mode = dpcs_pkg::DPCS_MODE_WIDE;
    pval = 32'h7ffffffc;
    cond.preset = 1'b1;
    settle();
    cond.preset = 1'b0;
    chk_word(rep.count, 32'h7ffffffc);
    chk_stat(rep.status, 8'h0b);
    cond.ack_load = 1'b1;
    settle();
    cond.ack_load = 1'b0;
    chk_stat(rep.status, 8'h03);
    step_up(3);
    chk_word(rep.count, 32'h7ffffffe);
    chk_stat(rep.status, 8'h00);
    roll = 1'b1;
    pval = 32'h7ffffffe;
    cond.preset = 1'b1;
    settle();
    cond.preset = 1'b0;
    chk_stat(rep.status, 8'h0b);
    step_up(1);
    chk_word(rep.count, 32'h80000000);
    step_down(1);
    chk_word(rep.count, 32'h7ffffffe);
    chk_stat(rep.status, 8'h0b);
    $display("test wide done");
  end
  endtask : test_wide
  task automatic stop_test();
  begin
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask : stop_test
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      $display("ERROR %0t timeout", $time);
      stop_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
    chk_stat(rep.status, 8'h00);
    test_run_latch();
    test_wrap();
    test_down();
    test_wide();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
